// *** common/rdlc_defines.svh ***
// constants for the rs232 dtr/dsr line-control block
// assumes a 20 MHz clock and six user ports (ports 2 to 7)
`ifndef RDLC_DEFINES_SVH
`define RDLC_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define RDLC_NPORT            6
`define RDLC_NLO              5
`define RDLC_ADDR_W           4
`define RDLC_DATA_W           32

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define RDLC_OFS_DTR_LO       4'h0
`define RDLC_OFS_DTR_HI       4'h1
`define RDLC_OFS_DSR_LO       4'h2
`define RDLC_OFS_DSR_HI       4'h3
`define RDLC_OFS_LST_LO       4'h4
`define RDLC_OFS_LST_HI       4'h5
`define RDLC_OFS_MODE         4'h6
`define RDLC_OFS_TXST         4'h7
`define RDLC_OFS_IRQ_ST       4'h8
`define RDLC_OFS_IRQ_MASK     4'h9

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define RDLC_DTR_W            2
`define RDLC_DSR_W            3
`define RDLC_LST_W            2
`define RDLC_TXST_W           4

// ----------------------------------------------------------------
// option encodings
// ----------------------------------------------------------------
`define RDLC_DTR_RUN          2'h0
`define RDLC_DTR_OFF          2'h1
`define RDLC_DTR_RXOK         2'h2
`define RDLC_DTR_RUN2         2'h3
`define RDLC_DSR_NONE         3'h0
`define RDLC_DSR_ON_TXRX      3'h1
`define RDLC_DSR_OFF_TXRX     3'h2
`define RDLC_DSR_BUSY         3'h3
`define RDLC_DSR_OFF_TX       3'h4

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define RDLC_RST_DTR_LO       10'h000
`define RDLC_RST_DTR_HI       2'h0
`define RDLC_RST_DSR_LO       15'h0000
`define RDLC_RST_DSR_HI       3'h0
`define RDLC_RST_MODE         6'h00
`define RDLC_RST_MASK         6'h00
`define RDLC_TXST_OK          4'h0
`define RDLC_TXST_BUSY_TMO    4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RDLC_CLK_HZ           20000000
`define RDLC_BUSY_TMO_MS      5000
`define RDLC_BUSY_TIMEOUT_CYC (`RDLC_BUSY_TMO_MS * (`RDLC_CLK_HZ / 1000))

`endif

// *** common/rdlc_pkg.sv ***
// types shared by the line-control block
// assumes rdlc_defines.svh is on the include path
`default_nettype none
`include "rdlc_defines.svh"

package rdlc_pkg;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`RDLC_ADDR_W-1:0] addr;
		logic [`RDLC_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} rdlc_bus_req_t;

	typedef struct packed {
		logic                   user_mode;
		logic [`RDLC_DTR_W-1:0] dtr_opt;
		logic [`RDLC_DSR_W-1:0] dsr_opt;
	} rdlc_port_cfg_t;

	typedef struct packed {
		logic dsr;
		logic tx_pending;
	} rdlc_port_in_t;

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_HELD,
		TX_ABORTED
	} rdlc_tx_state_t;

endpackage

`default_nettype wire

// *** design/rdlc_port_line.sv ***
// one port's dtr drive, dsr gating and busy timeout
// assumes inputs synchronous to clk; timeout in clk cycles
`timescale 1ns/1ps
`default_nettype none
`include "rdlc_defines.svh"

module rdlc_port_line #(
	parameter int unsigned TIMEOUT_CYC = `RDLC_BUSY_TIMEOUT_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire rdlc_pkg::rdlc_port_cfg_t cfg,
	input  wire logic                    running,
	input  wire rdlc_pkg::rdlc_port_in_t  pin,
	output logic                         dtr_q,
	output logic                         tx_en_q,
	output logic                         rx_en_q,
	output logic                         timeout_q
);
	import rdlc_pkg::*;

	localparam int CW = $clog2(TIMEOUT_CYC + 1);

	rdlc_tx_state_t state_q, state_d;
	logic [CW-1:0]  cnt_q, cnt_d;
	logic           busy_mode, counting, expire;
	logic           tx_gate, rx_gate, dtr_d;

	// ------------------------------------------------------------
	// busy timeout
	// ------------------------------------------------------------
	always_comb begin
		busy_mode = cfg.user_mode && running
			&& cfg.dsr_opt == `RDLC_DSR_BUSY;
		counting  = busy_mode && pin.tx_pending && !pin.dsr
			&& state_q != TX_ABORTED;
		expire    = counting && cnt_q == CW'(TIMEOUT_CYC - 1); // R8
		cnt_d     = (counting && !expire) ? cnt_q + CW'(1) : '0; // R15
		state_d   = state_q;
		unique case (state_q)
			TX_IDLE: begin
				if (expire)
					state_d = TX_ABORTED;
				else if (counting)
					state_d = TX_HELD;
			end
			TX_HELD: begin
				if (expire)
					state_d = TX_ABORTED; // R8
				else if (!counting)
					state_d = TX_IDLE; // R7
			end
			TX_ABORTED: begin
				// rest of the message is dropped until software ends it
				if (!pin.tx_pending || !busy_mode)
					state_d = TX_IDLE;
			end
			default: state_d = TX_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// gating and dtr
	// ------------------------------------------------------------
	always_comb begin
		tx_gate = 1'b1;
		rx_gate = 1'b1;
		dtr_d   = 1'b1;
		if (!cfg.user_mode) begin
			dtr_d = 1'b1; // R12
		end else if (!running) begin
			tx_gate = 1'b0; // R13
			rx_gate = 1'b0; // R13
			dtr_d   = 1'b0; // R1
		end else begin
			unique case (cfg.dsr_opt)
				`RDLC_DSR_ON_TXRX: begin
					tx_gate = pin.dsr; // R11
					rx_gate = pin.dsr;
				end
				`RDLC_DSR_OFF_TXRX: begin
					tx_gate = !pin.dsr; // R11
					rx_gate = !pin.dsr;
				end
				// relies on the terminal dropping dsr while it is full
				`RDLC_DSR_BUSY: tx_gate = pin.dsr
					&& state_d != TX_ABORTED; // R6 R7 R10
				`RDLC_DSR_OFF_TX: tx_gate = !pin.dsr; // R11
				default: ;
			endcase
			unique case (cfg.dtr_opt)
				`RDLC_DTR_RUN: dtr_d = 1'b1; // R1
				`RDLC_DTR_OFF: dtr_d = 1'b0; // R2
				`RDLC_DTR_RXOK: dtr_d = rx_gate; // R3
				`RDLC_DTR_RUN2: dtr_d = 1'b1; // R4
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= TX_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dtr_q     <= 1'b0;
			tx_en_q   <= 1'b0;
			rx_en_q   <= 1'b0;
			timeout_q <= 1'b0;
		end else begin
			dtr_q     <= dtr_d;
			tx_en_q   <= tx_gate;
			rx_en_q   <= rx_gate;
			timeout_q <= expire;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_maint_dtr_on: assert property ( // R12
		!cfg.user_mode |=> dtr_q && tx_en_q && rx_en_q)
		else $error("maintenance port lost dtr or data path");
	a_stop_all_off: assert property ( // R13
		cfg.user_mode && !running |=> !dtr_q && !tx_en_q && !rx_en_q)
		else $error("stopped port still enabled");
	a_run_dtr_on: assert property ( // R1
		cfg.user_mode && running && cfg.dtr_opt == `RDLC_DTR_RUN
		|=> dtr_q)
		else $error("dtr off while running with option 00");
	a_dtr_forced_off: assert property ( // R2
		cfg.user_mode && cfg.dtr_opt == `RDLC_DTR_OFF |=> !dtr_q)
		else $error("dtr on with option 01");
	a_dtr_follows_rx: assert property ( // R3
		cfg.user_mode && cfg.dtr_opt == `RDLC_DTR_RXOK
		|=> dtr_q == rx_en_q)
		else $error("dtr does not follow receive state");
	a_dtr_opt_same: assert property ( // R4
		cfg.user_mode && running && cfg.dtr_opt == `RDLC_DTR_RUN2
		|=> dtr_q)
		else $error("option 11 differs from option 00");
	a_busy_blocks_tx: assert property ( // R6
		busy_mode && !pin.dsr |=> !tx_en_q)
		else $error("transmit enabled while terminal busy");
	a_dsr_on_gate: assert property ( // R11
		cfg.user_mode && running && cfg.dsr_opt == `RDLC_DSR_ON_TXRX
		|=> tx_en_q == $past(pin.dsr) && rx_en_q == $past(pin.dsr))
		else $error("dsr-on gating wrong");
	a_abort_holds: assert property ( // R8
		timeout_q |-> state_q == TX_ABORTED && !tx_en_q)
		else $error("timeout did not abort transmit");
	a_cnt_restart: assert property ( // R15
		pin.dsr |=> cnt_q == '0)
		else $error("busy counter not restarted by dsr");
	a_resume_busy: assert property ( // R7
		busy_mode && pin.dsr && state_q != TX_ABORTED
		&& !expire ##1 busy_mode && pin.dsr |=> tx_en_q)
		else $error("transmit not resumed when dsr returned");

	c_timeout: cover property (timeout_q);
	c_resume: cover property (state_q == TX_HELD ##1 state_q == TX_IDLE);
endmodule

`default_nettype wire

// *** design/rdlc_line_ctrl.sv ***
// register file and six port line controllers for ports 2 to 7
// assumes a plain register port with read data one cycle after the strobe
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rdlc_defines.svh"

// Behaviour
// [R1] option 00: dtr on running, off stopped
// [R2] option 01: dtr always off
// [R3] option 10: dtr on while reception possible
// [R4] option 11 behaves exactly like 00
// [R5] options apply to user-mode ports two-seven only
// [R6] busy mode: transmit only while dsr on
// [R7] busy mode: pause on dsr off, resume
// [R8] dsr off too long: timeout, abort transmission
// [R9] timeout writes error code to transmit status
// [R10] terminal drops dsr while busy
// [R11] dsr options 001, 010, 100 gate tx/rx (option 100 gates tx only here)
// [R12] maintenance mode: dsr ignored, dtr on
// [R13] stopped user mode: tx/rx disabled
// [R14] line status dtr/dsr latched each scan end
// [R15] busy counter restarts on dsr, counts pending
module rdlc_line_ctrl #(
	parameter int unsigned BUSY_TIMEOUT_CYC = `RDLC_BUSY_TIMEOUT_CYC
) (
	input  wire logic                                      clk,
	input  wire logic                                      rst,
	input  wire rdlc_pkg::rdlc_bus_req_t                    bus_req,
	input  wire logic                                      running,
	input  wire logic                                      scan_end,
	input  wire rdlc_pkg::rdlc_port_in_t [`RDLC_NPORT-1:0]  port_in,
	output logic [`RDLC_DATA_W-1:0]                        rd_data_q,
	output logic [`RDLC_NPORT-1:0]                         dtr_q,
	output logic [`RDLC_NPORT-1:0]                         tx_en_q,
	output logic [`RDLC_NPORT-1:0]                         rx_en_q,
	output logic [`RDLC_NPORT-1:0]                         tx_abort_q,
	output logic                                           irq_q
);
	import rdlc_pkg::*;

	localparam int NP  = `RDLC_NPORT;
	localparam int NL  = `RDLC_NLO;
	localparam int DW  = `RDLC_DTR_W;
	localparam int SW  = `RDLC_DSR_W;
	localparam int LW  = `RDLC_LST_W;
	localparam int TW  = `RDLC_TXST_W;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input rdlc_bus_req_t req,
		input logic [`RDLC_ADDR_W-1:0] ofs);
		return req.addr == ofs;
	endfunction

	function automatic rdlc_port_cfg_t port_cfg(input int idx,
		input logic [NP*DW-1:0] dtr_all,
		input logic [NP*SW-1:0] dsr_all,
		input logic [NP-1:0] mode);
		rdlc_port_cfg_t c;
		c.user_mode = mode[idx];
		c.dtr_opt   = dtr_all[idx*DW +: DW];
		c.dsr_opt   = dsr_all[idx*SW +: SW];
		return c;
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [NL*DW-1:0]  dtr_lo_q;
	logic [DW-1:0]     dtr_hi_q;
	logic [NL*SW-1:0]  dsr_lo_q;
	logic [SW-1:0]     dsr_hi_q;
	logic [NP-1:0]     mode_q;
	logic [NP*LW-1:0]  line_st_q;
	logic [NP*TW-1:0]  txst_q;
	logic [NP-1:0]     irq_st_q, irq_st_d;
	logic [NP-1:0]     irq_mask_q;
	logic [NP-1:0]     tx_pend_q;
	logic [NP-1:0]     timeout;
	logic [NP-1:0]     dtr_w, tx_en_w, rx_en_w;
	logic [`RDLC_DATA_W-1:0] rd_val;

	// ------------------------------------------------------------
	// option and mode registers
	// ------------------------------------------------------------
	// options act immediately; a change mid-message takes effect at once
	always_ff @(posedge clk) begin
		if (rst) begin
			dtr_lo_q <= `RDLC_RST_DTR_LO;
			dtr_hi_q <= `RDLC_RST_DTR_HI;
			dsr_lo_q <= `RDLC_RST_DSR_LO;
			dsr_hi_q <= `RDLC_RST_DSR_HI;
			mode_q   <= `RDLC_RST_MODE;
		end else if (bus_req.wr) begin
			if (hit(bus_req, `RDLC_OFS_DTR_LO))
				dtr_lo_q <= bus_req.wdata[NL*DW-1:0];
			if (hit(bus_req, `RDLC_OFS_DTR_HI))
				dtr_hi_q <= bus_req.wdata[DW-1:0];
			if (hit(bus_req, `RDLC_OFS_DSR_LO))
				dsr_lo_q <= bus_req.wdata[NL*SW-1:0];
			if (hit(bus_req, `RDLC_OFS_DSR_HI))
				dsr_hi_q <= bus_req.wdata[SW-1:0];
			if (hit(bus_req, `RDLC_OFS_MODE))
				mode_q <= bus_req.wdata[NP-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq_mask_q <= `RDLC_RST_MASK;
		else if (bus_req.wr && hit(bus_req, `RDLC_OFS_IRQ_MASK))
			irq_mask_q <= bus_req.wdata[NP-1:0];
	end

	// ------------------------------------------------------------
	// port controllers
	// ------------------------------------------------------------
	// port 1 has no line control, so only ports 2 to 7 exist here
	for (genvar i = 0; i < NP; i++) begin : g_port
		rdlc_port_line #(
			.TIMEOUT_CYC(BUSY_TIMEOUT_CYC)
		) u_port (
			.clk       (clk),
			.rst       (rst),
			.cfg       (port_cfg(i, {dtr_hi_q, dtr_lo_q},
				{dsr_hi_q, dsr_lo_q}, mode_q)), // R5
			.running   (running),
			.pin       (port_in[i]),
			.dtr_q     (dtr_w[i]),
			.tx_en_q   (tx_en_w[i]),
			.rx_en_q   (rx_en_w[i]),
			.timeout_q (timeout[i])
		);
	end

	assign dtr_q      = dtr_w;
	assign tx_en_q    = tx_en_w;
	assign rx_en_q    = rx_en_w;
	assign tx_abort_q = timeout;

	// ------------------------------------------------------------
	// line status, refreshed at scan end
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			line_st_q <= '0;
		end else if (scan_end) begin
			for (int i = 0; i < NP; i++)
				line_st_q[i*LW +: LW] <= {dtr_w[i], port_in[i].dsr}; // R14
		end
	end

	// ------------------------------------------------------------
	// transmit status
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			tx_pend_q <= '0;
		else
			for (int i = 0; i < NP; i++)
				tx_pend_q[i] <= port_in[i].tx_pending;
	end

	// a new message clears the code; a timeout in the same cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			txst_q <= '0;
		end else begin
			for (int i = 0; i < NP; i++) begin
				if (timeout[i])
					txst_q[i*TW +: TW] <= `RDLC_TXST_BUSY_TMO; // R9
				else if (port_in[i].tx_pending && !tx_pend_q[i])
					txst_q[i*TW +: TW] <= `RDLC_TXST_OK;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupts: sticky timeouts, cleared by reading the status
	// ------------------------------------------------------------
	always_comb begin
		irq_st_d = irq_st_q;
		if (bus_req.rd && hit(bus_req, `RDLC_OFS_IRQ_ST))
			irq_st_d = '0;
		irq_st_d = irq_st_d | timeout;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_st_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_q    <= |(irq_st_d & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		rd_val = '0;
		unique case (bus_req.addr)
			`RDLC_OFS_DTR_LO:   rd_val[NL*DW-1:0] = dtr_lo_q;
			`RDLC_OFS_DTR_HI:   rd_val[DW-1:0]    = dtr_hi_q;
			`RDLC_OFS_DSR_LO:   rd_val[NL*SW-1:0] = dsr_lo_q;
			`RDLC_OFS_DSR_HI:   rd_val[SW-1:0]    = dsr_hi_q;
			`RDLC_OFS_LST_LO:   rd_val[NL*LW-1:0] = line_st_q[NL*LW-1:0];
			`RDLC_OFS_LST_HI:   rd_val[LW-1:0]    = line_st_q[NP*LW-1 -: LW];
			`RDLC_OFS_MODE:     rd_val[NP-1:0]    = mode_q;
			`RDLC_OFS_TXST:     rd_val[NP*TW-1:0] = txst_q;
			`RDLC_OFS_IRQ_ST:   rd_val[NP-1:0]    = irq_st_q;
			`RDLC_OFS_IRQ_MASK: rd_val[NP-1:0]    = irq_mask_q;
			default:            rd_val = '0;
		endcase
	end

	// data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (rst)
			rd_data_q <= '0;
		else
			rd_data_q <= bus_req.rd ? rd_val : '0;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_status_at_scan: assert property ( // R14
		scan_end |=> line_st_q[1:0] == {$past(dtr_w[0]),
			$past(port_in[0].dsr)})
		else $error("line status not latched at scan end");
	a_status_holds: assert property ( // R14
		!scan_end |=> $stable(line_st_q))
		else $error("line status changed between scan ends");
	a_txst_code: assert property ( // R9
		timeout[0] |=> txst_q[TW-1:0] == `RDLC_TXST_BUSY_TMO)
		else $error("timeout did not post error code");
	a_irq_sticky: assert property ( // R8
		timeout[0] && irq_mask_q[0] |=> irq_st_q[0] ##0 irq_q)
		else $error("timeout did not raise interrupt");
	a_mode_gates: assert property ( // R5
		!mode_q[0] |=> dtr_q[0])
		else $error("option applied outside user mode");

	c_abort: cover property (tx_abort_q != '0);
	c_irq_read: cover property (irq_q ##1 bus_req.rd
		&& hit(bus_req, `RDLC_OFS_IRQ_ST));
	c_scan: cover property (scan_end && line_st_q != '0);
endmodule

`default_nettype wire

// *** dv/rdlc_term_model.sv ***
// remote terminal (printer) seen from one serial port
// assumes the bench commands busy as a level on clk
`timescale 1ns/1ps
`default_nettype none

module rdlc_term_model #(
	parameter int unsigned LAG = 3
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic busy,
	output logic      dsr_q
);
	// ------------------------------------------------------------
	// ready line
	// ------------------------------------------------------------
	// lag models a slow printer; keep it at two or more
	logic [LAG-1:0] pipe_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			pipe_q <= '1;
		end else begin
			pipe_q <= {pipe_q[LAG-2:0], ~busy};
		end
	end

	assign dsr_q = pipe_q[LAG-1];
endmodule

`default_nettype wire

// *** dv/rdlc_line_ctrl_tb.sv ***
// self-checking bench for the line-control block
// assumes rdlc_pkg is compiled first, defines on the include path
`timescale 1ns/1ps
`default_nettype none
`include "rdlc_defines.svh"

module rs232_dtr_dsr_line_control_tb_top;
	import rdlc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int unsigned TMO = 20;
	localparam int unsigned LAG = 3;
	typedef struct packed {
		logic [1:0] dopt;
		logic [2:0] sopt;
		logic       run;
		logic       dsr;
		logic [2:0] res;
	} rdlc_row_t;
	// res is {dtr, tx_en, rx_en} of port 2
	rdlc_row_t rows [15] = '{10'h017, 10'h000, 10'h113, 10'h31f, 10'h308,
		10'h230, 10'h23f, 10'h258, 10'h257, 10'h29d, 10'h297, 10'h075,
		10'h07f, 10'h0b7, 10'h128};
	logic                            clk, rst, running, scan_end, busy, irq;
	rdlc_bus_req_t                   bus_req;
	rdlc_port_in_t [`RDLC_NPORT-1:0] pin;
	logic [`RDLC_NPORT-1:0]          dsr_v, pend_v, dtr, tx_en, rx_en, abrt;
	logic [`RDLC_DATA_W-1:0]         rdata;
	wire logic                       term_dsr;
	int                              errors, comparisons, n;

	always_comb begin
		for (int i = 0; i < `RDLC_NPORT; i++) begin
			pin[i].dsr = (i == 0) ? term_dsr : dsr_v[i];
			pin[i].tx_pending = pend_v[i];
		end
	end

	rdlc_line_ctrl #(.BUSY_TIMEOUT_CYC(TMO)) uut (.clk(clk), .rst(rst),
		.bus_req(bus_req), .running(running), .scan_end(scan_end),
		.port_in(pin), .rd_data_q(rdata), .dtr_q(dtr), .tx_en_q(tx_en),
		.rx_en_q(rx_en), .tx_abort_q(abrt), .irq_q(irq));
	rdlc_term_model #(.LAG(LAG)) term (.clk(clk), .rst(rst), .busy(busy),
		.dsr_q(term_dsr));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [3:0] a,
			input logic [31:0] e);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask

	// edges from dsr falling to the abort pulse of port 2
	task automatic measure(output int c);
		c = 0;
		while (term_dsr !== 1'b0 && c < 20) begin
			wt(1);
			c++;
		end
		c = 0;
		while (abrt[0] !== 1'b1 && c < 60) begin
			wt(1);
			c++;
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		complete_run();
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		running = 1'b0;
		scan_end = 1'b0;
		busy = 1'b0;
		bus_req = '0;
		dsr_v = '0;
		pend_v = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wt(2);
		chk("maint_lines", {dtr, tx_en, rx_en}, 32'h3ffff);
		rd_chk("rst_dtr_lo", `RDLC_OFS_DTR_LO, 32'h0);
		rd_chk("rst_dsr_lo", `RDLC_OFS_DSR_LO, 32'h0);
		rd_chk("rst_mode", `RDLC_OFS_MODE, 32'h0);
		$display("test reset done");

		// status latched only at scan end, dtr on in maintenance
		@(posedge clk);
		dsr_v <= 6'h14;
		wt(LAG + 2);
		@(posedge clk);
		scan_end <= 1'b1;
		@(posedge clk);
		scan_end <= 1'b0;
		wt(2);
		rd_chk("lst_lo", `RDLC_OFS_LST_LO, 32'h3bb);
		rd_chk("lst_hi", `RDLC_OFS_LST_HI, 32'h2);
		@(posedge clk);
		dsr_v <= 6'h00;
		bus_wr(`RDLC_OFS_LST_LO, 32'h0);
		wt(3);
		rd_chk("lst_hold", `RDLC_OFS_LST_LO, 32'h3bb);
		rd_chk("unmapped", 4'hf, 32'h0);
		$display("test line status done");

		// port 3 stays in maintenance throughout the table
		bus_wr(`RDLC_OFS_MODE, 32'h3d);
		for (int r = 0; r < 15; r++) begin
			bus_wr(`RDLC_OFS_DTR_LO, {30'h0, rows[r].dopt});
			bus_wr(`RDLC_OFS_DSR_LO, {29'h0, rows[r].sopt});
			@(posedge clk);
			running <= rows[r].run;
			busy <= ~rows[r].dsr;
			wt(LAG + 4);
			chk("lines", {dtr[0], tx_en[0], rx_en[0]},
				rows[r].res);
			chk("maint_dtr", dtr[1], 1'b1);
		end
		$display("test option table done");

		bus_wr(`RDLC_OFS_DSR_LO, 32'h3);
		bus_wr(`RDLC_OFS_IRQ_MASK, 32'h1);
		// last table row leaves the controller stopped; busy mode needs run
		@(posedge clk);
		running <= 1'b1;
		busy <= 1'b0;
		pend_v <= 6'h01;
		wt(LAG + 3);
		@(posedge clk);
		busy <= 1'b1;
		wt(12);
		chk("held_tx", tx_en[0], 1'b0);
		@(posedge clk);
		busy <= 1'b0;
		wt(LAG + 3);
		chk("resume_tx", tx_en[0], 1'b1);
		rd_chk("txst_ok", `RDLC_OFS_TXST, 32'h0);
		@(posedge clk);
		busy <= 1'b1;
		measure(n);
		chk("tmo_cycles", n, TMO);
		// irq follows the sticky bit, one edge after the abort pulse
		wt(1);
		chk("irq_on", irq, 1'b1);
		@(posedge clk);
		busy <= 1'b0;
		wt(LAG + 3);
		chk("tx_refused", tx_en[0], 1'b0);
		rd_chk("txst_code", `RDLC_OFS_TXST, {28'h0, `RDLC_TXST_BUSY_TMO});
		rd_chk("irq_st", `RDLC_OFS_IRQ_ST, 32'h1);
		rd_chk("irq_clr", `RDLC_OFS_IRQ_ST, 32'h0);
		chk("irq_off", irq, 1'b0);
		$display("test busy timeout done");

		// a masked event still sets the sticky status bit
		bus_wr(`RDLC_OFS_IRQ_MASK, 32'h0);
		@(posedge clk);
		pend_v <= 6'h00;
		wt(2);
		@(posedge clk);
		pend_v <= 6'h01;
		busy <= 1'b1;
		measure(n);
		chk("tmo_again", n, TMO);
		wt(1);
		chk("irq_masked", irq, 1'b0);
		rd_chk("irq_st_m", `RDLC_OFS_IRQ_ST, 32'h1);
		// port 7 option lives in its own word
		bus_wr(`RDLC_OFS_DTR_HI, 32'h1);
		wt(2);
		chk("p7_dtr", dtr[5], 1'b0);
		rd_chk("p7_opt", `RDLC_OFS_DTR_HI, 32'h1);
		$display("test masked timeout done");

		@(posedge clk);
		rst <= 1'b1;
		busy <= 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wt(2);
		chk("rerst_lines", {dtr, tx_en, rx_en}, 32'h3ffff);
		rd_chk("rerst_txst", `RDLC_OFS_TXST, 32'h0);
		$display("test second reset done");
		complete_run();
	end
endmodule

`default_nettype wire
